// ===== pacs_pkg.sv
package pacs_pkg;

	localparam logic [4:0] PACS_OFS_DRIFT = 5'h14;
	localparam logic [4:0] PACS_OFS_AUX = 5'h18;
	localparam logic [4:0] PACS_OFS_TEST = 5'h15;

	localparam int PACS_BIT_FAST = 15;
	localparam int PACS_BIT_SLOW = 14;
	localparam int PACS_BIT_JAB_DIS = 15;
	localparam int PACS_BIT_FORCE_LINK = 14;
	localparam int PACS_BIT_SQ_LO = 6;
	localparam int PACS_BIT_EDGE_LO = 4;
	localparam int PACS_BIT_AN_IND = 3;
	localparam int PACS_BIT_FORCE_FAST_SPEED_PIN_IND = 2;
	localparam int PACS_BIT_SPD_IND = 1;
	localparam int PACS_BIT_FDX_IND = 0;

	localparam logic [15:0] PACS_DRIFT_RSVD_RST = 16'h0200;
	localparam logic [15:0] PACS_TEST_RST = 16'h0000;
	localparam logic [1:0] PACS_SQ_RST = 2'h0;
	localparam logic [1:0] PACS_EDGE_RST = 2'h3;

	localparam int PACS_JAB_MAX_NS = 20000;
	localparam int PACS_CLK_NS = 5;
	localparam int PACS_JAB_CYC = PACS_JAB_MAX_NS / PACS_CLK_NS;

	typedef enum logic [1:0] {
		PACS_SQ_NORMAL,
		PACS_SQ_LOW,
		PACS_SQ_HIGH,
		PACS_SQ_ILLEGAL
	} pacs_sq_t;

	typedef struct packed {
		logic jabber_disable;
		logic force_link;
		pacs_sq_t squelch;
		logic [1:0] edge_rate;
	} pacs_ctrl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} pacs_req_t;

endpackage

// ===== pacs_regs.sv
`timescale 1ns/1ps
// Behaviour
// - extended fifo mode and fast receive data set drift bit 15, else 0.
// - extended fifo mode and slow receive data set drift bit 14, else 0.
// - test register holds sixteen reserved bits, resetting to zero.
// - aux bit 15 stores jabber disable; reset clears it; readable.
// - jabber enabled in 10BASE-T cuts transmitter on overlong transmit request.
// - aux bit 14 forces 10BASE-T link pass; reset clears it; readable.
// - aux bits 7:6 pick squelch normal, low, high; reset 00; 11 forbidden.
// - chosen squelch drives carrier and link detection; field reads back.
// - aux bits 5:4 set transmit edge rate 1 to 4 ns; reset 11.
// - aux bit 3 is control bit 12 and autoneg strap both high.
// - aux bit 2 is 0 when both straps low or strap high with bits 12,13 low.
// - aux bit 1 shows live speed; reset value follows force strap while autoneg strap is low, else 10.
// - speed reads 10BASE-T while autoneg exchange runs.
// - aux bit 0 shows full duplex; reset value follows duplex strap.
module pacs_regs
	import pacs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire pacs_req_t req_i,
	output logic [15:0] rdata_o,
	input wire logic ctrl_an_enable_i,
	input wire logic ctrl_speed_sel_i,
	input wire logic autoneg_strap_pin_i,
	input wire logic force_fast_speed_pin_i,
	input wire logic full_duplex_strap_pin_i,
	input wire logic ext_fifo_mode_i,
	input wire logic fifo_fast_i,
	input wire logic fifo_slow_i,
	input wire logic link_speed_100_i,
	input wire logic link_full_duplex_i,
	input wire logic an_exchange_busy_i,
	input wire logic mode_10bt_i,
	input wire logic tx_request_i,
	output logic tx_enable_o,
	output pacs_ctrl_t ctrl_o,
	output logic high_squelch_select_o,
	output logic low_squelch_select_o
);

	////////////////////////////////////////////////////////////////////////
	logic [1:0] an_sync_r, force_fast_speed_pin_sync_r, fdx_sync_r;
	logic strap_done_r;
	logic [1:0] fill_r;
	pacs_ctrl_t ctrl_r, ctrl_nxt;
	logic [15:0] test_r, test_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [$clog2(PACS_JAB_CYC+1)-1:0] jab_cnt_r, jab_cnt_nxt;
	logic jab_trip_r, jab_trip_nxt;
	logic speed_r, speed_nxt, fdx_r, fdx_nxt;
	logic an_ind, force_fast_speed_pin_ind;

	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			an_sync_r <= 2'h0;
			force_fast_speed_pin_sync_r <= 2'h0;
			fdx_sync_r <= 2'h0;
		end
		else
		begin
			an_sync_r <= {an_sync_r[0], autoneg_strap_pin_i};
			force_fast_speed_pin_sync_r <= {force_fast_speed_pin_sync_r[0], force_fast_speed_pin_i};
			fdx_sync_r <= {fdx_sync_r[0], full_duplex_strap_pin_i};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// indications decoded from straps and control bits
	always_comb
	begin
		an_ind = ctrl_an_enable_i & an_sync_r[1];
		force_fast_speed_pin_ind = 1'b1;
		if (!an_sync_r[1] && !force_fast_speed_pin_sync_r[1])
		begin
			force_fast_speed_pin_ind = 1'b0;
		end
		if (an_sync_r[1] && !ctrl_an_enable_i && !ctrl_speed_sel_i)
		begin
			force_fast_speed_pin_ind = 1'b0;
		end
	end

	// strap values seed speed and duplex until the link reports
	always_comb
	begin
		speed_nxt = speed_r;
		fdx_nxt = fdx_r;
		if (!strap_done_r)
		begin
			speed_nxt = force_fast_speed_pin_sync_r[1] & ~an_sync_r[1];
			fdx_nxt = fdx_sync_r[1];
		end
		else
		begin
			speed_nxt = link_speed_100_i & ~an_exchange_busy_i;
			fdx_nxt = link_full_duplex_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			strap_done_r <= 1'b0;
			fill_r <= 2'h0;
			speed_r <= 1'b0;
			fdx_r <= 1'b0;
		end
		else
		begin
			// two edges fill the synchronisers; the third seeds from settled straps
			fill_r <= {fill_r[0], 1'b1};
			strap_done_r <= fill_r[1];
			speed_r <= speed_nxt;
			fdx_r <= fdx_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// writable control and test register
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		test_nxt = test_r;
		if (req_i.wr && req_i.addr == PACS_OFS_AUX)
		begin
			ctrl_nxt.jabber_disable = req_i.wdata[PACS_BIT_JAB_DIS];
			ctrl_nxt.force_link = req_i.wdata[PACS_BIT_FORCE_LINK];
			ctrl_nxt.squelch = pacs_sq_t'(req_i.wdata[PACS_BIT_SQ_LO +: 2]);
			ctrl_nxt.edge_rate = req_i.wdata[PACS_BIT_EDGE_LO +: 2];
		end
		if (req_i.wr && req_i.addr == PACS_OFS_TEST)
		begin
			test_nxt = req_i.wdata;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctrl_r <= '{1'b0, 1'b0, pacs_sq_t'(PACS_SQ_RST), PACS_EDGE_RST};
			test_r <= PACS_TEST_RST;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			test_r <= test_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// jabber timer; in 10BASE-T with jabber enabled the transmit gate drops once a request overruns
	always_comb
	begin
		jab_cnt_nxt = jab_cnt_r;
		jab_trip_nxt = jab_trip_r;
		if (!tx_request_i)
		begin
			jab_cnt_nxt = '0;
			jab_trip_nxt = 1'b0;
		end
		else if (jab_cnt_r < ($clog2(PACS_JAB_CYC+1))'(PACS_JAB_CYC))
		begin
			jab_cnt_nxt = jab_cnt_r + 1'b1;
		end
		else
		begin
			jab_trip_nxt = mode_10bt_i & ~ctrl_r.jabber_disable;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			jab_cnt_r <= '0;
			jab_trip_r <= 1'b0;
		end
		else
		begin
			jab_cnt_r <= jab_cnt_nxt;
			jab_trip_r <= jab_trip_nxt;
		end
	end

	assign tx_enable_o = tx_request_i & ~jab_trip_r;

	////////////////////////////////////////////////////////////////////////
	// read mux; indication bits are never stored from a write
	always_comb
	begin
		rdata_nxt = 16'h0000;
		if (req_i.rd)
		begin
		unique case (req_i.addr)
			PACS_OFS_DRIFT:
			begin
				rdata_nxt = PACS_DRIFT_RSVD_RST;
				rdata_nxt[PACS_BIT_FAST] = ext_fifo_mode_i & fifo_fast_i;
				rdata_nxt[PACS_BIT_SLOW] = ext_fifo_mode_i & fifo_slow_i;
			end
			PACS_OFS_AUX:
			begin
				rdata_nxt[PACS_BIT_JAB_DIS] = ctrl_r.jabber_disable;
				rdata_nxt[PACS_BIT_FORCE_LINK] = ctrl_r.force_link;
				rdata_nxt[PACS_BIT_SQ_LO +: 2] = ctrl_r.squelch;
				rdata_nxt[PACS_BIT_EDGE_LO +: 2] = ctrl_r.edge_rate;
				rdata_nxt[PACS_BIT_AN_IND] = an_ind;
				rdata_nxt[PACS_BIT_FORCE_FAST_SPEED_PIN_IND] = force_fast_speed_pin_ind;
				rdata_nxt[PACS_BIT_SPD_IND] = speed_r;
				rdata_nxt[PACS_BIT_FDX_IND] = fdx_r;
			end
			PACS_OFS_TEST: rdata_nxt = test_r;
			default: rdata_nxt = 16'h0000;
		endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			rdata_r <= 16'h0000;
		else
			rdata_r <= rdata_nxt;
	end

	assign rdata_o = rdata_r;
	assign ctrl_o = ctrl_r;
	// illegal code 11 treated as normal squelch in the detector
	assign high_squelch_select_o = ctrl_r.squelch == PACS_SQ_HIGH;
	assign low_squelch_select_o = ctrl_r.squelch == PACS_SQ_LOW;

	////////////////////////////////////////////////////////////////////////
	AST_JAB_DIS_WR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.wr && req_i.addr == PACS_OFS_AUX |=> ctrl_o.jabber_disable == $past(req_i.wdata[15]))
		else $error("jabber disable not stored");
	AST_FORCE_LINK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.wr && req_i.addr == PACS_OFS_AUX |=> ctrl_o.force_link == $past(req_i.wdata[14]))
		else $error("force link not stored");
	AST_FAST: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.rd && req_i.addr == PACS_OFS_DRIFT |=> rdata_o[15] == $past(ext_fifo_mode_i & fifo_fast_i))
		else $error("fast bit wrong");
	AST_SLOW: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.rd && req_i.addr == PACS_OFS_DRIFT |=> rdata_o[14] == $past(ext_fifo_mode_i & fifo_slow_i))
		else $error("slow bit wrong");
	AST_AN_IND: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.rd && req_i.addr == PACS_OFS_AUX && !ctrl_an_enable_i |=> !rdata_o[3])
		else $error("autoneg indication wrong");
	AST_SPD_AN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		strap_done_r && an_exchange_busy_i |=> !speed_r)
		else $error("speed not 10 during autoneg");
	AST_JABBER: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		tx_request_i && mode_10bt_i && !ctrl_r.jabber_disable
		&& jab_cnt_r == ($clog2(PACS_JAB_CYC+1))'(PACS_JAB_CYC) |=> !tx_enable_o)
		else $error("transmitter not shut off");
	AST_SQ_MAP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!(high_squelch_select_o && low_squelch_select_o))
		else $error("both squelch selects high");
	AST_TEST_RD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.wr && req_i.addr == PACS_OFS_TEST |=> test_r == $past(req_i.wdata))
		else $error("test register readback wrong");
	COV_AUX_WR: cover property (@(posedge clk_sys_i) req_i.wr && req_i.addr == PACS_OFS_AUX);
	COV_JAB: cover property (@(posedge clk_sys_i) jab_trip_r);
	COV_FAST: cover property (@(posedge clk_sys_i) rdata_o[15]);

endmodule

// ===== pacs_sme.sv
`timescale 1ns/1ps
// management side: calls start just after an edge, hold until the edge that takes them
module pacs_sme
	import pacs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic [15:0] rdata_i,
	output pacs_req_t req_o
);
	initial req_o = '0;
	// one idle cycle after each request, so no signal is set twice in one step
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		#1 req_o = '0;
		@(posedge clk_sys_i);
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_sys_i);
		#1 d = rdata_i;
		req_o = '0;
		@(posedge clk_sys_i);
		#1;
	endtask
	// reserved bits go back as read
	task automatic rmw(input logic [4:0] a, input logic [15:0] set);
		logic [15:0] d;
		rd(a, d);
		wr(a, d | set);
	endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
	import pacs_pkg::*;
	logic clk_sys_i = 1'b0, reset_i = 1'b1;
	logic an_en = 1'b1, spd_sel = 1'b0, autoneg_strap_pin = 1'b1, force_fast_speed_pin = 1'b0, full_duplex_strap_pin = 1'b1;
	logic ext = 1'b0, fast = 1'b0, slow = 1'b0, spd100 = 1'b0, lfdx = 1'b1;
	logic busy = 1'b0, m10 = 1'b1, txreq = 1'b0, tx_en, high_squelch_select, low_squelch_select;
	logic [15:0] rdata, v;
	logic [1:0] e;
	pacs_ctrl_t ctrl;
	pacs_req_t req;
	int mismatches = 0, compares = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	pacs_sme u_pacs_sme (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .req_o(req));
	pacs_regs u_pacs_regs (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(req),
		.rdata_o(rdata), .ctrl_an_enable_i(an_en), .ctrl_speed_sel_i(spd_sel),
		.autoneg_strap_pin_i(autoneg_strap_pin), .force_fast_speed_pin_i(force_fast_speed_pin),
		.full_duplex_strap_pin_i(full_duplex_strap_pin), .ext_fifo_mode_i(ext), .fifo_fast_i(fast),
		.fifo_slow_i(slow), .link_speed_100_i(spd100), .link_full_duplex_i(lfdx),
		.an_exchange_busy_i(busy), .mode_10bt_i(m10), .tx_request_i(txreq),
		.tx_enable_o(tx_en), .ctrl_o(ctrl), .high_squelch_select_o(high_squelch_select),
		.low_squelch_select_o(low_squelch_select));
	task automatic check(input string n, input logic [15:0] x, input logic [15:0] g);
		compares++;
		if (x !== g)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic finish_test;
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////
	// defaults after a reset; straps an=1 force_fast_speed_pin=0 fdx=1, live 10 Mbps full duplex
	task automatic t_reset;
		reset_i = 1'b1;
		cyc(6);
		reset_i = 1'b0;
		cyc(3);
		u_pacs_sme.rd(PACS_OFS_AUX, v);
		check("aux_reset", 16'h003D, v);
		u_pacs_sme.rd(PACS_OFS_TEST, v);
		check("test_reg", 16'h0000, v);
		u_pacs_sme.rmw(PACS_OFS_TEST, 16'h0000);
		u_pacs_sme.rd(PACS_OFS_TEST, v);
		check("test_rmw", 16'h0000, v);
		u_pacs_sme.rd(5'h03, v);
		check("unmapped", 16'h0000, v);
	endtask
	// control fields, including squelch codes 00 to 10 and every edge code; reserved 13:8 kept zero
	task automatic t_ctrl;
		u_pacs_sme.wr(PACS_OFS_AUX, 16'hC0AF);
		u_pacs_sme.rd(PACS_OFS_AUX, v);
		check("aux_wr", 16'hC0AD, v);
		check("ctrl", 16'h003A, 16'(ctrl));
		for (int s = 0; s < 3; s++)
			for (int r = 0; r < 4; r++)
			begin
				u_pacs_sme.wr(PACS_OFS_AUX, {8'h00, s[1:0], r[1:0], 4'h0});
				u_pacs_sme.rd(PACS_OFS_AUX, v);
				check("sq_edge", 16'({s[1:0], r[1:0]}), 16'(v[7:4]));
				check("sq_sel", 16'({s == 2, s == 1}), 16'({high_squelch_select, low_squelch_select}));
				check("ctrl_lo", 16'({s[1:0], r[1:0]}), 16'(ctrl[3:0]));
			end
	endtask
	// negotiation and force indications over all strap/control combinations
	task automatic t_ind;
		for (int i = 0; i < 16; i++)
		begin
			{autoneg_strap_pin, force_fast_speed_pin, an_en, spd_sel} = i[3:0];
			cyc(4);
			u_pacs_sme.rd(PACS_OFS_AUX, v);
			e[1] = an_en & autoneg_strap_pin;
			e[0] = !((!autoneg_strap_pin && !force_fast_speed_pin) || (autoneg_strap_pin && !an_en && !spd_sel));
			check("an_force", 16'(e), 16'(v[3:2]));
		end
		for (int i = 0; i < 8; i++)
		begin
			{spd100, busy, lfdx} = i[2:0];
			cyc(2);
			u_pacs_sme.rd(PACS_OFS_AUX, v);
			check("spd_fdx", 16'({spd100 & !busy, lfdx}), 16'(v[1:0]));
		end
	endtask
	// drift flags; read-only bits survive a read-modify-write that sets them
	task automatic t_drift;
		for (int i = 0; i < 8; i++)
		begin
			{ext, fast, slow} = i[2:0];
			cyc(1);
			u_pacs_sme.rd(PACS_OFS_DRIFT, v);
			check("drift", {ext & fast, ext & slow, 14'h0200}, v);
		end
		{ext, fast, slow} = 3'b000;
		u_pacs_sme.rmw(PACS_OFS_DRIFT, 16'hC000);
		u_pacs_sme.rd(PACS_OFS_DRIFT, v);
		check("drift_ro", 16'h0200, v);
	endtask
	// overlong transmit request cut off only while jabber detection is on
	task automatic t_jab(input logic dis);
		u_pacs_sme.wr(PACS_OFS_AUX, {dis, 15'h0030});
		txreq = 1'b1;
		cyc(10);
		check("tx_early", 16'h0001, 16'(tx_en));
		cyc(PACS_JAB_CYC + 10);
		check("tx_late", 16'(dis), 16'(tx_en));
		txreq = 1'b0;
		cyc(4);
	endtask
	initial
	begin
		t_reset();
		t_ctrl();
		t_ind();
		{autoneg_strap_pin, force_fast_speed_pin, an_en, spd_sel, spd100, busy, lfdx} = 7'b1010001;
		t_drift();
		t_jab(1'b0);
		t_jab(1'b1);
		t_reset();
		finish_test();
	end
endmodule
